// *** common/wtim_defs.vh ***
`ifndef WTIM_DEFS_VH
`define WTIM_DEFS_VH

// ************************************
// Base tick derived from the clock
// ************************************
`define WTIM_CLK_MHZ      200
`define WTIM_TICK_US      1
`define WTIM_TICK_CYC     8'd200

// ************************************
// Register addresses and reset values
// ************************************
`define WTIM_ADDR_WAKE    7'h05
`define WTIM_ADDR_TIMER   7'h06
`define WTIM_ADDR_MASK    7'h09
`define WTIM_WAKE_RST     16'h0020
`define WTIM_TIMER_RST    16'h0000
`define WTIM_MASK_RST     16'h0140
`define WTIM_WAKE_WMASK   16'h3E67
`define WTIM_TIMER_WMASK  16'hEFF7
`define WTIM_MASK_WMASK   16'h01FF

// ************************************
// Field positions
// ************************************
`define WTIM_FILT_HI      13
`define WTIM_FILT_LO      11
`define WTIM_WKEN_HI      6
`define WTIM_WKEN_LO      5
`define WTIM_T2ON_HI      15
`define WTIM_T2ON_LO      13
`define WTIM_T2PER_HI     11
`define WTIM_T2PER_LO     9
`define WTIM_CYC_HI       8
`define WTIM_CYC_LO       7
`define WTIM_T1ON_HI      6
`define WTIM_T1ON_LO      4
`define WTIM_T1PER_HI     2
`define WTIM_T1PER_LO     0
`define WTIM_REPEAT_BIT   8
`define WTIM_DOGOFF_BIT   7
`define WTIM_DOGIRQ_BIT   6
`define WTIM_FAULT_BIT    5
`define WTIM_BRIDGE_BIT   4

// ************************************
// Field codes
// ************************************
`define WTIM_WKEN_ON      2'h1
`define WTIM_FILT_S64     3'h1
`define WTIM_FILT_CYC1    3'h2
`define WTIM_FILT_CYC2    3'h3
`define WTIM_CYC_T1       2'h1
`define WTIM_CYC_T2       2'h2
`define WTIM_ON_LAST      3'h5

// ************************************
// Times in microseconds (one tick each)
// ************************************
`define WTIM_ON1_US       21'd100
`define WTIM_ON2_US       21'd300
`define WTIM_ON3_US       21'd1000
`define WTIM_ON4_US       21'd10000
`define WTIM_ON5_US       21'd20000
`define WTIM_PER0_US      21'd10000
`define WTIM_PER1_US      21'd20000
`define WTIM_PER2_US      21'd50000
`define WTIM_PER3_US      21'd100000
`define WTIM_PER4_US      21'd200000
`define WTIM_PER5_US      21'd500000
`define WTIM_PER6_US      21'd1000000
`define WTIM_PER7_US      21'd2000000
`define WTIM_FILT16_US    7'd16
`define WTIM_FILT64_US    7'd64
`define WTIM_IRQ_PULSE_US 7'd100
`define WTIM_IRQ_REP_US   14'd10000

`endif

// *** logic/wtim_ctrl.v ***
// Notes on behaviour
// RL1: Fail-safe entry forces the wake-input enable field to 01.
// RL2: In fail-safe, filter selection ignored; static sensing, 16 us filter.
// RL3: Second timer on-time 000 off, then 0.1, 0.3, 1, 10, 20 ms.
// RL4: Both period fields map 10,20,50,100,200,500 ms, 1 s, 2 s.
// RL5: Cyclic wake select: 00 none, 01 first timer, 10 second timer.
// RL6: First timer on-time uses the same coding as the second.
// RL7: Timer starts by itself once an on-time code from 1 to 5 is written.
// RL8: Repeat enable pulses the interrupt while anything stays pending.
// RL9: Mask bit 7 switches the watchdog off in development mode.
// RL10: Mask bit 6 turns a development-mode watchdog failure into a pulse.
// RL11: Mask bit 5 turns a frame or checksum fault into a pulse.
// RL12: Mask bit 4 turns a bridge status flag into a pulse.
// RL13: Every enabled event pulses the active-low interrupt output.
// RL14: A repeated event pulses again although its status is already set.
// RL15: Pin wake only while the wake-input enable is 01, which is also its reset value.
// RL16: A selected timer raises wake at each period end, window per on-time.
// RL17: A timer with on-time 000 stays stopped and gives no wake.
`timescale 1ns/1ps
`include "wtim_defs.vh"

module wtim_ctrl #(
  parameter [7:0] TICK_CYC = `WTIM_TICK_CYC
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [6:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata,
  input  wire        fail_safe_mode,
  input  wire        devmode,
  input  wire        wake_input_pin,
  input  wire        dog_fail_devmode,
  input  wire        frame_fault,
  input  wire        crc_fault,
  input  wire        bridge_status_set,
  input  wire        irq_pending,
  output wire        irq_out_n,
  output wire        dog_enable,
  output wire        wake_request,
  output wire        first_timer_window,
  output wire        second_timer_window,
  output wire        wake_pin_level
);

  // ************************************
  // Registers and state
  // ************************************
  reg  [15:0] wake_input_control_reg;
  reg  [15:0] wake_input_control_next;
  reg  [15:0] cyclic_timer_control_reg;
  reg  [15:0] interrupt_event_mask_reg;
  reg  [15:0] rdata_reg;
  reg  [15:0] rdata_next;
  reg         fail_safe_d_reg;
  reg  [7:0]  tick_cnt_reg;
  reg         tick_reg;
  reg  [6:0]  pulse_cnt_reg;
  reg         irq_n_reg;
  reg  [13:0] rep_cnt_reg;
  reg         rep_fire_reg;
  reg         dog_enable_reg;
  reg         wake_request_reg;

  // ************************************
  // Field views
  // ************************************
  wire [2:0] wake_filter_select   =
    wake_input_control_reg[`WTIM_FILT_HI:`WTIM_FILT_LO];
  wire [1:0] wake_input_enable    =
    wake_input_control_reg[`WTIM_WKEN_HI:`WTIM_WKEN_LO];
  wire [2:0] second_timer_on_time =
    cyclic_timer_control_reg[`WTIM_T2ON_HI:`WTIM_T2ON_LO];
  wire [2:0] second_timer_period  =
    cyclic_timer_control_reg[`WTIM_T2PER_HI:`WTIM_T2PER_LO];
  wire [1:0] cyclic_wake_select   =
    cyclic_timer_control_reg[`WTIM_CYC_HI:`WTIM_CYC_LO];
  wire [2:0] first_timer_on_time  =
    cyclic_timer_control_reg[`WTIM_T1ON_HI:`WTIM_T1ON_LO];
  wire [2:0] first_timer_period   =
    cyclic_timer_control_reg[`WTIM_T1PER_HI:`WTIM_T1PER_LO];
  wire periodic_irq_repeat_en     =
    interrupt_event_mask_reg[`WTIM_REPEAT_BIT];
  wire dog_off_in_devmode         =
    interrupt_event_mask_reg[`WTIM_DOGOFF_BIT];
  wire dog_fail_irq_en_devmode    =
    interrupt_event_mask_reg[`WTIM_DOGIRQ_BIT];
  wire frame_fault_irq_en         =
    interrupt_event_mask_reg[`WTIM_FAULT_BIT];
  wire bridge_status_irq_en       =
    interrupt_event_mask_reg[`WTIM_BRIDGE_BIT];

  // ************************************
  // Write decode
  // ************************************
  wire wr_wake  = reg_wr && (reg_addr == `WTIM_ADDR_WAKE);
  wire wr_timer = reg_wr && (reg_addr == `WTIM_ADDR_TIMER);
  wire wr_mask  = reg_wr && (reg_addr == `WTIM_ADDR_MASK);
  wire fs_entry = fail_safe_mode && !fail_safe_d_reg;

  // ************************************
  // Microsecond tick divider
  // ************************************
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_CYC - 8'h01)
    begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
      tick_reg     <= 1'b0;
    end
  end

  // ************************************
  // Wake input control register
  // ************************************
  // Device rewrite on fail-safe entry wins over a host write
  always @*
  begin
    wake_input_control_next = wake_input_control_reg;
    if (wr_wake)
      wake_input_control_next = reg_wdata & `WTIM_WAKE_WMASK;
    if (fs_entry)
      wake_input_control_next[`WTIM_WKEN_HI:`WTIM_WKEN_LO] = `WTIM_WKEN_ON; // RL1
  end

  // Register writes and fail-safe edge detect
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      wake_input_control_reg   <= `WTIM_WAKE_RST;
      cyclic_timer_control_reg <= `WTIM_TIMER_RST;
      interrupt_event_mask_reg <= `WTIM_MASK_RST;
      fail_safe_d_reg          <= 1'b0;
    end
    else
    begin
      wake_input_control_reg <= wake_input_control_next;
      fail_safe_d_reg        <= fail_safe_mode;
      if (wr_timer)
        cyclic_timer_control_reg <= reg_wdata & `WTIM_TIMER_WMASK;
      if (wr_mask)
        interrupt_event_mask_reg <= reg_wdata & `WTIM_MASK_WMASK;
    end
  end

  // ************************************
  // Read port
  // ************************************
  // Unmapped addresses read as zero
  always @*
  begin
    case (reg_addr)
      `WTIM_ADDR_WAKE:  rdata_next = wake_input_control_reg;
      `WTIM_ADDR_TIMER: rdata_next = cyclic_timer_control_reg;
      `WTIM_ADDR_MASK:  rdata_next = interrupt_event_mask_reg;
      default:          rdata_next = 16'h0000;
    endcase
  end

  // Read data held until the next read
  always @(posedge ref_clk)
  begin
    if (reset)
      rdata_reg <= 16'h0000;
    else if (reg_rd)
      rdata_reg <= rdata_next;
  end

  // ************************************
  // Cyclic timers
  // ************************************
  wire t1_window;
  wire t1_period_end;
  wire t1_on_end;
  wire t2_window;
  wire t2_period_end;
  wire t2_on_end;

  // First timer, runs once its on-time is a code from 1 to 5
  wtim_timer u_first_timer (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .tick           (tick_reg),
    .restart        (wr_timer),
    .on_code        (first_timer_on_time),   // RL6
    .per_code       (first_timer_period),    // RL4
    .on_window_reg  (t1_window),             // RL7
    .period_end_reg (t1_period_end),
    .on_end_reg     (t1_on_end)
  );

  // Second timer, same structure
  wtim_timer u_second_timer (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .tick           (tick_reg),
    .restart        (wr_timer),
    .on_code        (second_timer_on_time),  // RL3
    .per_code       (second_timer_period),   // RL4
    .on_window_reg  (t2_window),             // RL17
    .period_end_reg (t2_period_end),
    .on_end_reg     (t2_on_end)
  );

  // ************************************
  // Wake input sensing
  // ************************************
  wire       filt_cyc1 = (wake_filter_select == `WTIM_FILT_CYC1);
  wire       filt_cyc2 = (wake_filter_select == `WTIM_FILT_CYC2);
  wire       cyc_mode  = !fail_safe_mode && (filt_cyc1 || filt_cyc2); // RL2
  wire       use_64    = !fail_safe_mode &&
                         (wake_filter_select == `WTIM_FILT_S64);      // RL2
  wire [6:0] filt_len  = use_64 ? `WTIM_FILT64_US : `WTIM_FILT16_US;
  wire       sample    = (filt_cyc1 && t1_on_end) || (filt_cyc2 && t2_on_end);
  wire       pin_edge;

  // Filtered and synchronised wake input
  wtim_wake_filter u_wake_filter (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .tick      (tick_reg),
    .pin       (wake_input_pin),
    .cyclic    (cyc_mode),
    .sample    (sample),
    .filt_us   (filt_len),
    .level_reg (wake_pin_level),
    .edge_reg  (pin_edge)
  );

  // ************************************
  // Wake request
  // ************************************
  wire timer_wake =
    ((cyclic_wake_select == `WTIM_CYC_T1) && t1_period_end) ||
    ((cyclic_wake_select == `WTIM_CYC_T2) && t2_period_end);   // RL5
  wire pin_wake = pin_edge && (wake_input_enable == `WTIM_WKEN_ON);

  // One-cycle wake pulse per timer period or pin edge
  always @(posedge ref_clk)
  begin
    if (reset)
      wake_request_reg <= 1'b0;
    else
      wake_request_reg <= timer_wake || pin_wake; // RL16
  end

  // ************************************
  // Watchdog enable
  // ************************************
  always @(posedge ref_clk)
  begin
    if (reset)
      dog_enable_reg <= 1'b1;
    else
      dog_enable_reg <= !(devmode && dog_off_in_devmode); // RL9
  end

  // ************************************
  // Interrupt events
  // ************************************
  wire ev_dog    = dog_fail_devmode && dog_fail_irq_en_devmode;     // RL10
  wire ev_fault  = (frame_fault || crc_fault) && frame_fault_irq_en; // RL11
  wire ev_bridge = bridge_status_set && bridge_status_irq_en;       // RL12
  // Each occurrence counts, whatever its status bit already shows
  wire ev_any    = ev_dog || ev_fault || ev_bridge;                  // RL14

  // Repeat timer while anything stays pending
  always @(posedge ref_clk)
  begin
    if (reset || !periodic_irq_repeat_en || !irq_pending)
    begin
      rep_cnt_reg  <= 14'h0000;
      rep_fire_reg <= 1'b0;
    end
    else
    begin
      rep_fire_reg <= 1'b0;
      if (tick_reg)
      begin
        if (rep_cnt_reg == `WTIM_IRQ_REP_US - 14'h0001)
        begin
          rep_cnt_reg  <= 14'h0000;
          rep_fire_reg <= 1'b1; // RL8
        end
        else
          rep_cnt_reg <= rep_cnt_reg + 14'h0001;
      end
    end
  end

  // Low pulse of fixed length, restarted by any new event
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      pulse_cnt_reg <= 7'h00;
      irq_n_reg     <= 1'b1;
    end
    else if (ev_any || rep_fire_reg)
    begin
      pulse_cnt_reg <= `WTIM_IRQ_PULSE_US;
      irq_n_reg     <= 1'b0; // RL13
    end
    else if (tick_reg && pulse_cnt_reg != 7'h00)
    begin
      pulse_cnt_reg <= pulse_cnt_reg - 7'h01;
      if (pulse_cnt_reg == 7'h01)
        irq_n_reg <= 1'b1;
    end
  end

  // ************************************
  // Outputs
  // ************************************
  assign reg_rdata           = rdata_reg;
  assign irq_out_n           = irq_n_reg;
  assign dog_enable          = dog_enable_reg;
  assign wake_request        = wake_request_reg;
  assign first_timer_window  = t1_window;
  assign second_timer_window = t2_window;

endmodule

// *** logic/wtim_timer.v ***
`timescale 1ns/1ps
`include "wtim_defs.vh"

module wtim_timer (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire       tick,
  input  wire       restart,
  input  wire [2:0] on_code,
  input  wire [2:0] per_code,
  output reg        on_window_reg,
  output reg        period_end_reg,
  output reg        on_end_reg
);

  // On-time code to microseconds, zero when off
  function [20:0] on_us;
    input [2:0] code;
    begin
      case (code)
        3'h1:    on_us = `WTIM_ON1_US;
        3'h2:    on_us = `WTIM_ON2_US;
        3'h3:    on_us = `WTIM_ON3_US;
        3'h4:    on_us = `WTIM_ON4_US;
        3'h5:    on_us = `WTIM_ON5_US;
        default: on_us = 21'd0;
      endcase
    end
  endfunction

  // Period code to microseconds
  function [20:0] per_us;
    input [2:0] code;
    begin
      case (code)
        3'h0:    per_us = `WTIM_PER0_US;
        3'h1:    per_us = `WTIM_PER1_US;
        3'h2:    per_us = `WTIM_PER2_US;
        3'h3:    per_us = `WTIM_PER3_US;
        3'h4:    per_us = `WTIM_PER4_US;
        3'h5:    per_us = `WTIM_PER5_US;
        3'h6:    per_us = `WTIM_PER6_US;
        default: per_us = `WTIM_PER7_US;
      endcase
    end
  endfunction

  reg  [20:0] cnt_reg;
  wire [20:0] on_len  = on_us(on_code);
  wire [20:0] per_len = per_us(per_code);
  // Off and reserved codes keep the timer stopped
  wire        run     = (on_code != 3'h0) && (on_code <= `WTIM_ON_LAST);

  // Period counter, restarted by a write to the control word
  always @(posedge ref_clk)
  begin
    if (reset || !run || restart)
    begin
      cnt_reg        <= 21'd0;
      on_window_reg  <= 1'b0;
      period_end_reg <= 1'b0;
      on_end_reg     <= 1'b0;
    end
    else
    begin
      on_window_reg  <= (cnt_reg < on_len);
      period_end_reg <= 1'b0;
      on_end_reg     <= 1'b0;
      if (tick)
      begin
        if (cnt_reg == per_len - 21'd1)
        begin
          cnt_reg        <= 21'd0;
          period_end_reg <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 21'd1;
        if (cnt_reg == on_len - 21'd1)
          on_end_reg <= 1'b1;
      end
    end
  end

endmodule

// *** logic/wtim_wake_filter.v ***
`timescale 1ns/1ps
`include "wtim_defs.vh"

module wtim_wake_filter (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire       tick,
  input  wire       pin,
  input  wire       cyclic,
  input  wire       sample,
  input  wire [6:0] filt_us,
  output reg        level_reg,
  output reg        edge_reg
);

  reg  [2:0] sync_reg;
  reg  [6:0] cnt_reg;
  // Change counts once the second and third stage agree
  wire       stable = (sync_reg[1] == sync_reg[2]);
  wire       cand   = sync_reg[2];
  wire       done   = (cnt_reg >= filt_us);
  // Cyclic sensing accepts only at the end of the on-time
  wire       accept = done && (!cyclic || sample);

  // Three-stage synchroniser
  always @(posedge ref_clk)
  begin
    if (reset)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], pin};
  end

  // Filter: new level must stand for the filter time
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_reg   <= 7'h00;
      level_reg <= 1'b0;
      edge_reg  <= 1'b0;
    end
    else
    begin
      edge_reg <= 1'b0;
      if (!stable || cand == level_reg)
        cnt_reg <= 7'h00;
      else if (accept)
      begin
        level_reg <= cand;
        edge_reg  <= 1'b1;
        cnt_reg   <= 7'h00;
      end
      else if (tick && !done)
        cnt_reg <= cnt_reg + 7'h01;
    end
  end

endmodule

// *** tb/wtim_ctrl_assertions.sv ***
`timescale 1ns/1ps
module wtim_ctrl_assertions #(
  parameter [7:0] TICK_CYC = 8'd200
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [6:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        devmode,
  input wire logic        dog_fail_devmode,
  input wire logic        frame_fault,
  input wire logic        crc_fault,
  input wire logic        bridge_status_set,
  input wire logic        irq_pending,
  input wire logic        irq_out_n,
  input wire logic        dog_enable,
  input wire logic        first_timer_window,
  input wire logic        second_timer_window
);
  logic [15:0] mask_reg;
  logic [15:0] timer_reg;
  logic [15:0] low_cnt_reg;
  wire         t1_off;
  wire         t2_off;
  wire         ev_en;

  // Shadow copies of the mask and timer words, and the low-time counter
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      mask_reg    <= 16'h0140;
      timer_reg   <= 16'h0000;
      low_cnt_reg <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == 7'h09)
        mask_reg <= reg_wdata & 16'h01FF;
      if (reg_wr && reg_addr == 7'h06)
        timer_reg <= reg_wdata & 16'hEFF7;
      low_cnt_reg <= irq_out_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
  end

  // Stopped timers and enabled event sources
  assign t1_off = (timer_reg[6:4] == 3'h0) || (timer_reg[6:4] > 3'h5);
  assign t2_off = (timer_reg[15:13] == 3'h0) || (timer_reg[15:13] > 3'h5);
  assign ev_en  = ((frame_fault | crc_fault) & mask_reg[5]) |
                  (bridge_status_set & mask_reg[4]) | (dog_fail_devmode & mask_reg[6]);

  a_fault_irq_low: assert property (@(posedge ref_clk) disable iff (reset)
    (frame_fault || crc_fault) && mask_reg[5] |=> !irq_out_n)
    else $error("fault event did not pull the interrupt low");
  a_bridge_irq_low: assert property (@(posedge ref_clk) disable iff (reset)
    bridge_status_set && mask_reg[4] |-> ##1 !irq_out_n)
    else $error("bridge event did not pull the interrupt low");
  a_dog_irq_low: assert property (@(posedge ref_clk) disable iff (reset)
    dog_fail_devmode && devmode && mask_reg[6] |=> !irq_out_n [*2])
    else $error("watchdog failure did not pull the interrupt low");
  a_dog_off_devmode: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> dog_enable == !$past(devmode && mask_reg[7]))
    else $error("watchdog enable does not follow mask and mode");
  a_irq_pulse_len: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(irq_out_n) |-> low_cnt_reg >= 98 * TICK_CYC)
    else $error("interrupt pulse too short");
  a_irq_fall_cause: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(irq_out_n) |-> $past(ev_en) || $past(mask_reg[8] && irq_pending, 2))
    else $error("interrupt fell without an enabled cause");
  a_first_stopped: assert property (@(posedge ref_clk) disable iff (reset)
    t1_off && $past(t1_off) |-> !first_timer_window)
    else $error("first timer window runs while stopped");
  a_second_stopped: assert property (@(posedge ref_clk) disable iff (reset)
    t2_off && $past(t2_off) |-> !second_timer_window)
    else $error("second timer window runs while stopped");
endmodule

bind wtim_ctrl wtim_ctrl_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .devmode(devmode), .dog_fail_devmode(dog_fail_devmode),
  .frame_fault(frame_fault), .crc_fault(crc_fault), .bridge_status_set(bridge_status_set),
  .irq_pending(irq_pending), .irq_out_n(irq_out_n), .dog_enable(dog_enable),
  .first_timer_window(first_timer_window), .second_timer_window(second_timer_window));

// *** tb/wtim_ctrl_bench.sv ***
`timescale 1ns/1ps
module wtim_ctrl_bench;
  reg          ref_clk = 0;
  reg          reset = 1;
  reg          fail_safe_mode = 0, devmode = 0, wake_input_pin = 0, dog_fail_devmode = 0;
  reg          frame_fault = 0, crc_fault = 0, bridge_status_set = 0, irq_pending = 0;
  wire [6:0]   reg_addr;
  wire [15:0]  reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd, irq_out_n, dog_enable, wake_request;
  wire         first_timer_window, second_timer_window, wake_pin_level;
  integer      mismatches = 0, check_count = 0, n, k;
  logic [15:0] rv;

  wtim_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  wtim_ctrl #(.TICK_CYC(8'd2)) dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fail_safe_mode(fail_safe_mode), .devmode(devmode), .wake_input_pin(wake_input_pin),
    .dog_fail_devmode(dog_fail_devmode), .frame_fault(frame_fault), .crc_fault(crc_fault),
    .bridge_status_set(bridge_status_set), .irq_pending(irq_pending), .irq_out_n(irq_out_n),
    .dog_enable(dog_enable), .wake_request(wake_request),
    .first_timer_window(first_timer_window), .second_timer_window(second_timer_window),
    .wake_pin_level(wake_pin_level));

  // Clock of 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  function logic sig(input integer s);
    case (s)
      0: sig = irq_out_n;
      1: sig = wake_request;
      2: sig = first_timer_window;
      3: sig = second_timer_window;
      default: sig = wake_pin_level;
    endcase
  endfunction

  // Bounded wait for an output level; a timeout ends the run
  task wait_sig(input integer s, input logic lvl, input integer max);
    begin
      n = 0;
      while (sig(s) !== lvl && n < max)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n >= max)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t wait on output %0d timed out", $time, s);
        stop_test;
      end
    end
  endtask

  // Counts cycles where an output leaves its idle level
  task quiet(input integer s, input logic idle, input integer c);
    begin
      n = 0;
      repeat (c)
      begin
        @(negedge ref_clk);
        if (sig(s) !== idle)
          n = n + 1;
      end
    end
  endtask

  task ev(input integer e);
    begin
      @(negedge ref_clk);
      frame_fault = (e == 0);
      crc_fault = (e == 1);
      bridge_status_set = (e == 2);
      dog_fail_devmode = (e == 3);
      @(negedge ref_clk);
      {frame_fault, crc_fault, bridge_status_set, dog_fail_devmode} = 4'h0;
    end
  endtask

  task t_regs;
    begin
      host.rd(7'h05, rv); chk(rv, 16'h0020);
      host.rd(7'h06, rv); chk(rv, 16'h0000);
      host.rd(7'h09, rv); chk(rv, 16'h0140);
      host.wr(7'h07, 16'hFFFF);
      host.rd(7'h07, rv); chk(rv, 16'h0000);
      host.wr(7'h06, 16'hFFFF);
      host.rd(7'h06, rv); chk(rv, 16'hEFF7);
      host.wr(7'h06, 16'h0000);
      host.wr(7'h09, 16'hFFFF);
      host.rd(7'h09, rv); chk(rv, 16'h01FF);
      $display("register test done");
    end
  endtask

  task t_irq;
    begin
      devmode = 1;
      for (k = 0; k < 4; k = k + 1)
      begin
        host.wr(7'h09, 16'h0000);
        ev(k); chk(irq_out_n, 1'b1);
        host.wr(7'h09, (k < 2) ? 16'h0020 : (k == 2) ? 16'h0010 : 16'h0040);
        ev(k); chk(irq_out_n, 1'b0);
        repeat (50) @(negedge ref_clk);
        ev(k);
        wait_sig(0, 1'b1, 400); chk(n > 190, 1'b1);
      end
      $display("interrupt test done");
    end
  endtask

  task t_dog;
    begin
      host.wr(7'h09, 16'h0080);
      repeat (3) @(negedge ref_clk); chk(dog_enable, 1'b0);
      devmode = 0;
      repeat (3) @(negedge ref_clk); chk(dog_enable, 1'b1);
      devmode = 1;
      host.wr(7'h09, 16'h0000);
      repeat (3) @(negedge ref_clk); chk(dog_enable, 1'b1);
      $display("watchdog test done");
    end
  endtask

  task t_pin;
    begin
      host.wr(7'h05, 16'h0820);
      wake_input_pin = 1;
      wait_sig(4, 1'b1, 300); chk(n > 120, 1'b1);
      @(negedge ref_clk); chk(wake_request, 1'b1);
      host.wr(7'h05, 16'h0800);
      fail_safe_mode = 1;
      repeat (3) @(negedge ref_clk);
      host.rd(7'h05, rv); chk(rv, 16'h0820);
      wake_input_pin = 0;
      wait_sig(4, 1'b0, 300); chk(n < 60, 1'b1);
      @(negedge ref_clk); chk(wake_request, 1'b1);
      fail_safe_mode = 0;
      $display("wake pin test done");
    end
  endtask

  task t_timer(input logic [15:0] val, input integer w, input logic [15:0] off);
    begin
      host.wr(7'h06, val);
      wait_sig(w, 1'b1, 20);
      wait_sig(w, 1'b0, 300); chk(n > 195 && n < 205, 1'b1);
      wait_sig(1, 1'b1, 21000); chk(n > 19600 && n < 20000, 1'b1);
      host.wr(7'h06, off);
      quiet(w, 1'b0, 300); chk(n[15:0], 16'h0000);
      $display("timer test done");
    end
  endtask

  // On-times 0.3 ms and 1 ms, both timers started by one write
  task t_ontime;
    begin
      host.wr(7'h06, 16'h6020);
      wait_sig(2, 1'b1, 20);
      wait_sig(2, 1'b0, 700); chk(n > 595 && n < 605, 1'b1);
      wait_sig(3, 1'b0, 1500); chk(n > 1395 && n < 1405, 1'b1);
      host.wr(7'h06, 16'h0000);
      $display("on-time test done");
    end
  endtask

  task t_rep;
    begin
      host.wr(7'h09, 16'h0120);
      irq_pending = 1;
      ev(0); chk(irq_out_n, 1'b0);
      wait_sig(0, 1'b1, 300);
      wait_sig(0, 1'b0, 21000); chk(n > 19500, 1'b1);
      wait_sig(0, 1'b1, 300);
      host.wr(7'h09, 16'h0020);
      quiet(0, 1'b1, 20500); chk(n[15:0], 16'h0000);
      $display("repeat test done");
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(negedge ref_clk);
    reset = 0;
    t_regs;
    t_irq;
    t_dog;
    t_pin;
    t_ontime;
    t_timer(16'h0090, 2, 16'h0080);
    t_timer(16'h2100, 3, 16'h0100);
    t_rep;
    stop_test;
  end
endmodule

// *** tb/wtim_host.sv ***
`timescale 1ns/1ps
module wtim_host (
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [6:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write strobe; released lines show inverted values, not stale ones
  task wr(input logic [6:0] a, input logic [15:0] d);
    begin
      @(negedge ref_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
    end
  endtask

  // One read strobe, data taken a full cycle later
  task rd(input logic [6:0] a, output logic [15:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      @(negedge ref_clk);
      d = reg_rdata;
    end
  endtask
endmodule
